//--- rtl/gfd_pkg.sv
package gfd_pkg;

  // control bit positions
  localparam int PRIMARY_SECONDARY_BIT = 31;
  localparam int SECONDARY_GFUNC_BIT = 13;
  localparam int FUNC_SWITCH_BIT = 0;
  localparam logic [31:0] MAX_FUNCTION = 32'h0000003F;
  localparam logic [31:0] LIST_ENTRIES = 32'h00000200;
  localparam logic [15:0] EXIT_REASON_GFUNC = 16'h003B;
  localparam int ENTRY_BYTES = 8;
  localparam logic [15:0] TAG_NONE_VPT = 16'h0000;
  localparam logic [11:0] TAG_NONE_PCT = 12'h000;

  // apb register offsets (byte addresses)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FUNC_CTRL_LO = 8'h04;
  localparam logic [7:0] OFS_FUNC_CTRL_HI = 8'h08;
  localparam logic [7:0] OFS_LIST_BASE_LO = 8'h0C;
  localparam logic [7:0] OFS_LIST_BASE_HI = 8'h10;
  localparam logic [7:0] OFS_ROOT_LO = 8'h14;
  localparam logic [7:0] OFS_ROOT_HI = 8'h18;
  localparam logic [7:0] OFS_TAGS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // control register fields
  localparam int CTL_PRIMARY31 = 0;
  localparam int CTL_SECONDARY13 = 1;
  localparam int CTL_VPT_ENABLE = 2;
  localparam int CTL_PAGING = 3;
  localparam int CTL_PAE = 4;
  localparam int CTL_LONG_MODE = 5;
  localparam int CTL_PCT_ENABLE = 6;
  localparam logic [31:0] RESET_CONTROL = 32'h00000000;
  localparam logic [63:0] RESET_ROOT = 64'h0000000000000000;

  typedef enum logic [2:0] {
    GFD_IDLE = 3'b000,
    GFD_FETCH = 3'b001,
    GFD_CHECK = 3'b010,
    GFD_DONE = 3'b011
  } gfd_state_type;

  typedef enum logic [1:0] {
    GFD_OUT_NEXT = 2'b00,
    GFD_OUT_FAULT = 2'b01,
    GFD_OUT_EXIT = 2'b10
  } gfd_outcome_type;

  // request from the decode stage
  typedef struct packed {
    logic [31:0] function_select_reg;
    logic [31:0] list_index_reg;
    logic [3:0] instr_length;
  } gfd_req_type;

  // result back to the pipeline
  typedef struct packed {
    gfd_outcome_type outcome;
    logic [15:0] exit_reason;
    logic [3:0] exit_instr_length;
  } gfd_resp_type;

endpackage : gfd_pkg

//--- rtl/gfd_dispatch.sv
`timescale 1ns/100ps

module gfd_dispatch (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire gfd_pkg::gfd_req_type req,
  output logic resp_valid,
  output gfd_pkg::gfd_resp_type resp,
  output logic mem_rd_valid,
  output logic [63:0] mem_rd_addr,
  input wire logic mem_rd_done,
  input wire logic [63:0] mem_rd_data,
  input wire logic root_candidate_ok,
  input wire logic [15:0] virtual_processor_tag_in,
  input wire logic [11:0] process_context_tag_in,
  output logic [63:0] ept_root_pointer,
  output logic [39:0] ept_root_tag,
  output logic [15:0] virtual_processor_tag,
  output logic [11:0] process_context_tag,
  output logic inval_vpt0,
  output logic retranslate_root,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // dispatcher: sequencing, fetch port and the answer to the pipeline
  gfd_pkg::gfd_state_type state;
  gfd_pkg::gfd_state_type next_state;
  gfd_pkg::gfd_req_type held;
  gfd_pkg::gfd_req_type next_held;
  logic [63:0] root;
  logic [63:0] next_root;
  logic [63:0] candidate;
  logic [63:0] next_candidate;
  gfd_pkg::gfd_resp_type resp_q;
  gfd_pkg::gfd_resp_type next_resp;
  logic resp_valid_q;
  logic next_resp_valid;
  logic rd_valid_q;
  logic next_rd_valid;
  logic [63:0] rd_addr_q;
  logic [63:0] next_rd_addr;
  logic inval_q;
  logic next_inval;
  logic retr_q;
  logic next_retr;

  // status flags: bit 0 switch done, bit 1 candidate refused
  logic [31:0] status;
  logic [31:0] next_status;

  // current tags as the translation logic sees them
  logic [15:0] vpt_q;
  logic [15:0] next_vpt;
  logic [11:0] pct_q;
  logic [11:0] next_pct;

  // register file seen over apb
  logic [31:0] control;
  logic [31:0] next_control;
  logic [63:0] func_ctrl;
  logic [63:0] next_func_ctrl;
  logic [63:0] list_base;
  logic [63:0] next_list_base;
  logic [31:0] prdata_q;
  logic [31:0] next_prdata;
  logic pready_q;
  logic next_pready;
  logic pslverr_q;
  logic next_pslverr;

  // decode helpers shared by the groups
  logic funcs_on;
  logic sel_in_range;
  logic sel_enabled;
  logic is_switch;
  logic index_ok;
  logic [63:0] entry_addr;
  logic switch_ok;
  logic switch_bad;
  logic apb_setup;
  logic apb_access;
  logic status_wr;
  logic [7:0] ofs;

  // every output is a flop of its group
  assign resp_valid = resp_valid_q;
  assign resp = resp_q;
  assign mem_rd_valid = rd_valid_q;
  assign mem_rd_addr = rd_addr_q;
  assign ept_root_pointer = root;
  assign ept_root_tag = root[51:12];
  assign virtual_processor_tag = vpt_q;
  assign process_context_tag = pct_q;
  assign inval_vpt0 = inval_q;
  assign retranslate_root = retr_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // secondary controls count only when activated by primary bit 31
  assign funcs_on = control[gfd_pkg::CTL_PRIMARY31] & control[gfd_pkg::CTL_SECONDARY13];
  // selector checks, judged on the request as it arrives
  assign sel_in_range = req.function_select_reg <= gfd_pkg::MAX_FUNCTION;
  assign sel_enabled = func_ctrl[req.function_select_reg[5:0]];
  assign is_switch = req.function_select_reg[5:0] == 6'h00;
  assign index_ok = req.list_index_reg < gfd_pkg::LIST_ENTRIES;
  // entry address: base plus eight times the index; index below 512 fits 9 bits
  assign entry_addr = list_base + {52'h0000000000000, req.list_index_reg[8:0], 3'h0};
  // outcome of the candidate check, only meaningful in the check state
  assign switch_ok = (state == gfd_pkg::GFD_CHECK) & root_candidate_ok;
  assign switch_bad = (state == gfd_pkg::GFD_CHECK) & ~root_candidate_ok;
  // apb phases; writes commit only at the edge where pready is seen high
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable & pready_q;
  assign ofs = paddr[7:0];
  assign status_wr = apb_access & pwrite & (ofs == gfd_pkg::OFS_STATUS);

  // dispatcher next state; apb and tag registers and status flags never touched here
  always_comb begin
    next_state = state;
    next_held = held;
    next_root = root;
    next_candidate = candidate;
    next_resp = resp_q;
    next_resp_valid = 1'b0;
    next_rd_valid = rd_valid_q;
    next_rd_addr = rd_addr_q;
    next_inval = 1'b0;
    next_retr = 1'b0;
    unique case (state)
      gfd_pkg::GFD_IDLE: begin
        // requests are taken only here; busy states ignore req_valid
        if (req_valid) begin
          next_held = req;
          next_resp.exit_reason = gfd_pkg::EXIT_REASON_GFUNC;
          next_resp.exit_instr_length = req.instr_length;
          if (!funcs_on || !sel_in_range) begin
            next_resp.outcome = gfd_pkg::GFD_OUT_FAULT;
            next_resp_valid = 1'b1;
          end else if (!sel_enabled) begin
            next_resp.outcome = gfd_pkg::GFD_OUT_EXIT;
            next_resp_valid = 1'b1;
          end else if (is_switch) begin
            if (!index_ok) begin
              next_resp.outcome = gfd_pkg::GFD_OUT_EXIT;
              next_resp_valid = 1'b1;
            end else begin
              next_rd_addr = entry_addr;
              next_rd_valid = 1'b1;
              next_state = gfd_pkg::GFD_FETCH;
            end
          end else begin
            // no other function has behaviour yet; report it as performed
            next_resp.outcome = gfd_pkg::GFD_OUT_NEXT;
            next_resp_valid = 1'b1;
          end
        end
      end
      gfd_pkg::GFD_FETCH: begin
        // wait for the whole 64-bit word before checking
        if (mem_rd_done) begin
          next_rd_valid = 1'b0;
          next_candidate = mem_rd_data;
          next_state = gfd_pkg::GFD_CHECK;
        end
      end
      gfd_pkg::GFD_CHECK: begin
        // the length comes from the held request, never from a later one
        next_resp.exit_reason = gfd_pkg::EXIT_REASON_GFUNC;
        next_resp.exit_instr_length = held.instr_length;
        if (switch_bad) begin
          next_resp.outcome = gfd_pkg::GFD_OUT_EXIT;
        end else begin
          next_root = candidate;
          next_resp.outcome = gfd_pkg::GFD_OUT_NEXT;
          next_inval = ~control[gfd_pkg::CTL_VPT_ENABLE];
          // pae paging outside long mode keeps cached directory pointers, so no root retranslate
          next_retr = control[gfd_pkg::CTL_PAGING] &
            (~control[gfd_pkg::CTL_PAE] | control[gfd_pkg::CTL_LONG_MODE]);
        end
        next_resp_valid = 1'b1;
        next_state = gfd_pkg::GFD_DONE;
      end
      gfd_pkg::GFD_DONE: begin
        // one quiet cycle so the next request sees the new root
        next_state = gfd_pkg::GFD_IDLE;
      end
      default: begin
        next_state = gfd_pkg::GFD_IDLE;
      end
    endcase
  end

  // dispatcher registers; reset loads constants only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= gfd_pkg::GFD_IDLE;
      held <= '0;
      root <= gfd_pkg::RESET_ROOT;
      candidate <= 64'h0000000000000000;
      resp_q <= '0;
      resp_valid_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_addr_q <= 64'h0000000000000000;
      inval_q <= 1'b0;
      retr_q <= 1'b0;
    end else begin
      state <= next_state;
      held <= next_held;
      root <= next_root;
      candidate <= next_candidate;
      resp_q <= next_resp;
      resp_valid_q <= next_resp_valid;
      rd_valid_q <= next_rd_valid;
      rd_addr_q <= next_rd_addr;
      inval_q <= next_inval;
      retr_q <= next_retr;
    end
  end

  // status: software write clears, a same-cycle hardware set wins
  always_comb begin
    next_status = status;
    if (status_wr) begin
      next_status = status & ~pwdata;
    end
    if (switch_ok) begin
      next_status[0] = 1'b1;
    end
    if (switch_bad) begin
      next_status[1] = 1'b1;
    end
  end

  // status register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status <= 32'h00000000;
    end else begin
      status <= next_status;
    end
  end

  // tags forced when their enables are clear
  always_comb begin
    next_vpt = control[gfd_pkg::CTL_VPT_ENABLE] ? virtual_processor_tag_in : gfd_pkg::TAG_NONE_VPT;
    next_pct = control[gfd_pkg::CTL_PCT_ENABLE] ? process_context_tag_in : gfd_pkg::TAG_NONE_PCT;
  end

  // tag registers; one cycle behind the core, harmless for a multi-cycle switch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vpt_q <= gfd_pkg::TAG_NONE_VPT;
      pct_q <= gfd_pkg::TAG_NONE_PCT;
    end else begin
      vpt_q <= next_vpt;
      pct_q <= next_pct;
    end
  end

  // apb slave: answer registered at setup, stands through the access phase
  always_comb begin
    next_control = control;
    next_func_ctrl = func_ctrl;
    next_list_base = list_base;
    next_prdata = 32'h00000000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // writes land at the access edge, the one where the master sees pready
    if (apb_access && pwrite) begin
      unique case (ofs)
        gfd_pkg::OFS_CONTROL: next_control = pwdata;
        gfd_pkg::OFS_FUNC_CTRL_LO: next_func_ctrl[31:0] = pwdata;
        gfd_pkg::OFS_FUNC_CTRL_HI: next_func_ctrl[63:32] = pwdata;
        // list is 4-KByte aligned, so the low twelve bits stay zero
        gfd_pkg::OFS_LIST_BASE_LO: next_list_base[31:0] = {pwdata[31:12], 12'h000};
        gfd_pkg::OFS_LIST_BASE_HI: next_list_base[63:32] = pwdata;
        default: next_control = control;
      endcase
    end
    if (apb_setup) begin
      next_pready = 1'b1;
      unique case (ofs)
        gfd_pkg::OFS_CONTROL: next_prdata = control;
        gfd_pkg::OFS_FUNC_CTRL_LO: next_prdata = func_ctrl[31:0];
        gfd_pkg::OFS_FUNC_CTRL_HI: next_prdata = func_ctrl[63:32];
        gfd_pkg::OFS_LIST_BASE_LO: next_prdata = list_base[31:0];
        gfd_pkg::OFS_LIST_BASE_HI: next_prdata = list_base[63:32];
        gfd_pkg::OFS_ROOT_LO: next_prdata = root[31:0];
        gfd_pkg::OFS_ROOT_HI: next_prdata = root[63:32];
        gfd_pkg::OFS_TAGS: next_prdata = {4'h0, pct_q, vpt_q};
        gfd_pkg::OFS_STATUS: next_prdata = status;
        default: next_pslverr = 1'b1;
      endcase
      // writes read back as zero
      if (pwrite) begin
        next_prdata = 32'h00000000;
      end
    end
  end

  // apb registers; the answer lasts exactly one cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      control <= gfd_pkg::RESET_CONTROL;
      func_ctrl <= 64'h0000000000000000;
      list_base <= 64'h0000000000000000;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      control <= next_control;
      func_ctrl <= next_func_ctrl;
      list_base <= next_list_base;
      prdata_q <= next_prdata;
      pready_q <= next_pready;
      pslverr_q <= next_pslverr;
    end
  end

endmodule : gfd_dispatch

//--- tb/gfd_sva.sv
`timescale 1ns/100ps
module gfd_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire gfd_pkg::gfd_req_type req,
  input wire logic resp_valid,
  input wire gfd_pkg::gfd_resp_type resp,
  input wire logic mem_rd_valid,
  input wire logic [63:0] mem_rd_addr,
  input wire logic mem_rd_done,
  input wire logic [63:0] mem_rd_data,
  input wire logic root_candidate_ok,
  input wire logic [63:0] ept_root_pointer
);
  gfd_pkg::gfd_req_type q;
  // request in flight; the bench never issues one while busy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else if (req_valid) q <= req;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_fault_sel: assert property (resp_valid && q.function_select_reg > 32'h3F |-> resp.outcome == 2'h1)
    else $error("selector above 63 not faulted");
  a_exit_info: assert property (resp_valid && resp.outcome == 2'h2 |->
    resp.exit_reason == 16'h003B && resp.exit_instr_length == q.instr_length) else $error("exit info wrong");
  a_index_fetch: assert property ($rose(mem_rd_valid) |-> q.list_index_reg < 32'h200)
    else $error("fetch for index 512 or more");
  a_func_zero: assert property ($rose(mem_rd_valid) |-> q.function_select_reg == 32'h0)
    else $error("fetch for a nonzero function");
  a_fetch_addr: assert property ($rose(mem_rd_valid) |-> mem_rd_addr[11:0] == {q.list_index_reg[8:0], 3'h0})
    else $error("fetch address wrong");
  a_one_read: assert property (mem_rd_done |=> !mem_rd_valid ##1 resp_valid)
    else $error("fetch not closed before answer");
  a_good_load: assert property (mem_rd_done ##1 root_candidate_ok |=> resp_valid &&
    resp.outcome == 2'h0 && ept_root_pointer == $past(mem_rd_data, 2)) else $error("root not loaded");
  a_bad_keep: assert property (mem_rd_done ##1 !root_candidate_ok |=> resp_valid &&
    resp.outcome == 2'h2 && $stable(ept_root_pointer)) else $error("bad candidate not refused");
  c_exit: cover property (resp_valid && resp.outcome == 2'h2);
  c_load: cover property (mem_rd_done ##1 root_candidate_ok);
  c_refuse: cover property (mem_rd_done ##1 !root_candidate_ok);
endmodule : gfd_sva

bind gfd_dispatch gfd_sva gfd_sva_i (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req(req),
  .resp_valid(resp_valid), .resp(resp), .mem_rd_valid(mem_rd_valid), .mem_rd_addr(mem_rd_addr),
  .mem_rd_done(mem_rd_done), .mem_rd_data(mem_rd_data), .root_candidate_ok(root_candidate_ok),
  .ept_root_pointer(ept_root_pointer));

//--- tb/gfd_mem_model.sv
`timescale 1ns/100ps
module gfd_mem_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_rd_valid,
  input wire logic [63:0] mem_rd_addr,
  input wire logic [1:0] lat,
  output logic mem_rd_done,
  output logic [63:0] mem_rd_data
);
  logic [1:0] cnt;
  logic served;
  // one answer per fetch after lat cycles; data toggles so stale values never match
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 2'h0;
      served <= 1'b0;
      mem_rd_done <= 1'b0;
      mem_rd_data <= 64'h0;
    end else begin
      mem_rd_done <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      cnt <= mem_rd_valid ? cnt + 2'h1 : 2'h0;
      served <= mem_rd_valid && served;
      if (mem_rd_valid && !served && cnt == lat) begin
        mem_rd_done <= 1'b1;
        mem_rd_data <= {mem_rd_addr[31:0] ^ 32'h5A5AC3C3, mem_rd_addr[31:0]};
        served <= 1'b1;
      end
    end
  end
endmodule : gfd_mem_model

//--- tb/tb_gfd_dispatch.sv
`timescale 1ns/100ps
module tb_gfd_dispatch;
  logic clock = 1'b0, rst_b = 1'b0, req_valid = 1'b0, ok = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [15:0] tag = 16'h1234;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, s, x;
  gfd_pkg::gfd_req_type req = '0;
  gfd_pkg::gfd_resp_type resp;
  logic resp_valid, mem_rd_valid, mem_rd_done, pready, pslverr, err, inval, retr;
  logic [39:0] ert;
  logic [15:0] vpt;
  logic [11:0] pct;
  logic [63:0] mem_rd_addr, mem_rd_data, root, f, base, exp_root = 64'h0;
  logic [6:0] ctl;
  int seed = 32'hD846, n_errors = 0, total_checks = 0, i;
  always #2.5 clock = ~clock;
  gfd_dispatch gfd_dispatch_i (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .resp_valid(resp_valid), .resp(resp), .mem_rd_valid(mem_rd_valid), .mem_rd_addr(mem_rd_addr),
    .mem_rd_done(mem_rd_done), .mem_rd_data(mem_rd_data), .root_candidate_ok(ok),
    .virtual_processor_tag_in(tag), .process_context_tag_in(tag[11:0]), .ept_root_pointer(root),
    .ept_root_tag(ert), .virtual_processor_tag(vpt), .process_context_tag(pct), .inval_vpt0(inval),
    .retranslate_root(retr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  gfd_mem_model gfd_mem_model_i (.clock(clock), .rst_b(rst_b), .mem_rd_valid(mem_rd_valid),
    .mem_rd_addr(mem_rd_addr), .lat(lat), .mem_rd_done(mem_rd_done), .mem_rd_data(mem_rd_data));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // list entry as the memory model builds it from the fetch address
  function automatic logic [63:0] entry(input logic [63:0] a);
    return {a[31:0] ^ 32'h5A5AC3C3, a[31:0]};
  endfunction : entry
  // one apb transfer; an idle cycle after it keeps psel from being driven twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // answer looked at mid-cycle, where it stands, then taken at the next rising edge
    do @(negedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // one instruction with selector s and index x; expectation worked out first
  task automatic run(input logic v);
    logic [1:0] o;
    logic [3:0] len;
    logic sw;
    int k;
    len = 4'($random(seed)) | 4'h1;
    tag <= 16'($random(seed));
    o = 2'h0;
    if (!(ctl[0] && ctl[1]) || s > 32'h3F) o = 2'h1;
    else if (!f[s[5:0]] || (s == 32'h0 && (x > 32'h1FF || !v))) o = 2'h2;
    else if (s == 32'h0) exp_root = entry(base + {x[28:0], 3'h0});
    sw = s == 32'h0 && o == 2'h0;
    ok <= v;
    req <= {s, x, len};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (resp_valid !== 1'b1 && k < 40);
    chk(64'(resp_valid), 64'h1);
    chk(64'(resp.outcome), 64'(o));
    if (o == 2'h2) chk({resp.exit_reason, 48'(resp.exit_instr_length)}, {16'h003B, 48'(len)});
    chk(root, exp_root);
    chk(64'(ert), 64'(exp_root[51:12]));
    chk(64'(inval), 64'(sw & ~ctl[2]));
    chk(64'(retr), 64'(sw & ctl[3] & (~ctl[4] | ctl[5])));
    chk(64'({vpt, pct}), 64'({ctl[2] ? tag : 16'h0000, ctl[6] ? tag[11:0] : 12'h000}));
    repeat (2) @(posedge clock);
  endtask : run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // the tests need about 1400 cycles; a hang is cut at 30000, about twenty times that
  initial begin
    #150000;
    n_errors++;
    stop_test;
  end
  // reset, register corner cases, then random instructions with boundary selectors and indexes
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    apb(1'b0, gfd_pkg::OFS_CONTROL, 32'h0);
    chk(64'(rd), 64'h0);
    apb(1'b1, gfd_pkg::OFS_ROOT_LO, 32'hFFFFFFFF);
    apb(1'b0, gfd_pkg::OFS_ROOT_LO, 32'h0);
    chk(64'(rd), 64'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(64'({err, rd}), 64'h100000000);
    for (i = 0; i < 64; i++) begin
      ctl = 7'($random(seed)) | (i % 4 != 0 ? 7'h03 : 7'h00);
      f = {32'($random(seed)), 32'($random(seed)) | 32'(i % 3 != 0)};
      base = {32'($random(seed)), 32'($random(seed))} & 64'h000FFFFFFFFFF000;
      apb(1'b1, gfd_pkg::OFS_CONTROL, 32'(ctl));
      apb(1'b1, gfd_pkg::OFS_FUNC_CTRL_LO, f[31:0]);
      apb(1'b1, gfd_pkg::OFS_FUNC_CTRL_HI, f[63:32]);
      apb(1'b1, gfd_pkg::OFS_LIST_BASE_LO, base[31:0]);
      apb(1'b1, gfd_pkg::OFS_LIST_BASE_HI, base[63:32]);
      s = i % 4 == 3 ? 32'h3F + 32'(i[2]) : (i % 4 == 2 ? 32'($unsigned($random(seed)) % 70) : 32'h0);
      x = i % 6 == 0 ? 32'h1FF + 32'(i[3]) : 32'($unsigned($random(seed)) % 600);
      lat <= 2'($random(seed));
      run(1'($random(seed)));
      $display("test %0d done", i);
    end
    apb(1'b1, gfd_pkg::OFS_STATUS, 32'h00000003);
    apb(1'b0, gfd_pkg::OFS_STATUS, 32'h0);
    chk(64'(rd), 64'h0);
    stop_test;
  end
endmodule : tb_gfd_dispatch
